//--- logic/pwm_timer_ctrl.sv
// interrupt flags, clock control and counter control of one pwm timer
// Summary of operation
// - capture overwriting data while its flag is still set raises overwrite
// - compare mode: counter equal to compare buffer sets compare flag
// - capture mode: capture load of counter value sets compare flag
// - counter reaching programmed maximum sets the max flag
// - counter reaching zero sets the zero flag
// - writing one clears a flag, zero leaves it, read shows state
// - interrupt request only while an enabled flag is set
// - debug run bit keeps clock running in debug mode, else stops it
// - divider field picks ratio per source family, others fixed at one
// - source field picks one of eight oscillators or external inputs
// - unsupported sources cannot be selected
// - busy bit high while max register loads; software waits for it
// - direction field: up, down, up/down, reserved
// - one-shot bit with direction forms the count mode
// - run starts only with channel enabled now or in same write
// - writing run zero while counting stops the count
// - one-shot end at max or zero clears run automatically
// - run reads one while counting, zero when idle
// - preset clears counter, or loads max in down mode, when enabled
// - channel enable gates the channel operating clock
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module pwm_timer_ctrl
  import pwm_ctrl_pkg::*;
#(
  parameter int unsigned NUM_CC        = 2,
  parameter logic [7:0]  SRC_SUPPORTED = SRC_ALL_SUPPORTED
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata_q,
  // clock sources, one-cycle ticks and synchronous level inputs
  input  wire logic              debug_mode,
  input  wire logic [3:0]        osc_tick,
  input  wire logic [1:0]        ext_clk_in,
  // events from the counter and compare/capture circuits
  input  wire cnt_event_t        cnt_event,
  input  wire logic [NUM_CC-1:0] cc_capture_mode,
  input  wire logic [NUM_CC-1:0] cc_match,
  input  wire logic [NUM_CC-1:0] cc_capture_load,
  // to the counter datapath and interrupt controller
  output logic                   irq_q,
  output logic                   chan_clk_en_q,
  output logic                   count_tick_q,
  output logic                   count_run_q,
  output count_dir_t             count_dir_q,
  output logic                   one_shot_q,
  output logic                   preset_clear_q,
  output logic                   preset_load_max_q,
  output logic [15:0]            max_value_q,
  output logic                   max_load_q
);

  localparam int unsigned FLAG_W = CC_FLAG_BASE + 2 * NUM_CC;

  clk_sel_t            clk_sel_q;
  cnt_ctl_t            ctl_q;
  logic [FLAG_W-1:0]   flag_q;
  logic [FLAG_W-1:0]   flag_set;
  logic [FLAG_W-1:0]   flag_clr;
  logic [FLAG_W-1:0]   int_en_q;
  logic [15:0]         max_shadow_q;
  logic [3:0]          busy_cnt_q;
  logic                max_busy;
  logic [1:0]          ext_prev_q;
  logic [3:0]          ext_rise_fall;
  logic                src_tick;
  logic [3:0]          div_eff;
  logic                gate_en;
  logic                wr_clk;
  logic                wr_ctl;
  logic                wr_flag;
  logic                wr_en_reg;
  logic                wr_max;
  logic                en_after_wr;
  logic                one_shot_end;
  logic [DATA_W-1:0]   rd_mux;
  clk_src_t            src_wr;
  count_dir_t          dir_wr;

  // address decode of single-cycle write strobes
  always_comb begin
    wr_clk    = reg_wr && (reg_addr == CLK_SEL_OFFSET);
    wr_ctl    = reg_wr && (reg_addr == CNT_CTL_OFFSET);
    wr_flag   = reg_wr && (reg_addr == INT_FLAG_OFFSET);
    wr_en_reg = reg_wr && (reg_addr == INT_EN_OFFSET);
    wr_max    = reg_wr && (reg_addr == MAX_VAL_OFFSET);
    src_wr    = clk_src_t'(reg_wdata[SRC_LSB +: 3]);
    dir_wr    = count_dir_t'(reg_wdata[DIR_LSB +: 2]);
  end

  // clock control register; writing an unsupported source keeps the old one
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_sel_q.debug_run            <= 1'b0;
      clk_sel_q.clock_divider_select <= DIV_RESET;
      clk_sel_q.clock_source_select  <= clk_src_t'(SRC_RESET);
    end else if (wr_clk) begin
      clk_sel_q.debug_run            <= reg_wdata[DBG_RUN_BIT];
      clk_sel_q.clock_divider_select <= reg_wdata[DIV_LSB +: 4];
      if (SRC_SUPPORTED[src_wr]) begin
        clk_sel_q.clock_source_select <= src_wr;
      end
    end
  end

  // external inputs are already synchronous; keep last level for edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_q <= 2'h0;
    end else begin
      ext_prev_q <= ext_clk_in;
    end
  end

  // rising edges for plain inputs, falling edges for inverted ones
  assign ext_rise_fall = {~ext_clk_in & ext_prev_q,
                          ext_clk_in & ~ext_prev_q};

  // source tick and effective divider code per source family
  always_comb begin
    src_tick = 1'b0;
    div_eff  = 4'h0;
    unique case (clk_sel_q.clock_source_select)
      SRC_INT_OSC: begin
        src_tick = osc_tick[0];
        div_eff  = clk_sel_q.clock_divider_select;
      end
      SRC_LOW_OSC: begin
        src_tick = osc_tick[1];
        // codes past the low-speed limit fall back to divide by one
        if (clk_sel_q.clock_divider_select <= LOW_SPEED_DIV_MAX) begin
          div_eff = clk_sel_q.clock_divider_select;
        end
      end
      SRC_HIGH_OSC: begin
        src_tick = osc_tick[2];
        div_eff  = clk_sel_q.clock_divider_select;
      end
      SRC_EXT_OSC:  src_tick = osc_tick[3];
      SRC_EXT_IN0:  src_tick = ext_rise_fall[0];
      SRC_EXT_IN1:  src_tick = ext_rise_fall[1];
      SRC_EXT_IN0N: src_tick = ext_rise_fall[2];
      SRC_EXT_IN1N: src_tick = ext_rise_fall[3];
    endcase
  end

  // clock gating: channel enable and the debug-mode hold
  assign gate_en = ctl_q.channel_enable
                   && (!debug_mode || clk_sel_q.debug_run);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_clk_en_q <= 1'b0;
    end else begin
      chan_clk_en_q <= gate_en;
    end
  end

  // count ticks only flow while running, so a stopped counter holds still
  clock_prescaler u_prescaler (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .gate_en  (gate_en && count_run_q),
    .src_tick (src_tick),
    .div_code (div_eff),
    .tick_q   (count_tick_q)
  );

  // counter control fields; reserved direction code is refused
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q.count_direction_select <= DIR_UP;
      ctl_q.one_shot_select        <= 1'b0;
      ctl_q.channel_enable         <= 1'b0;
    end else if (wr_ctl) begin
      if (dir_wr != DIR_RSVD) begin
        ctl_q.count_direction_select <= dir_wr;
      end
      ctl_q.one_shot_select <= reg_wdata[ONE_SHOT_BIT];
      ctl_q.channel_enable  <= reg_wdata[ENABLE_BIT];
    end
  end

  always_comb begin
    count_dir_q = ctl_q.count_direction_select;
    one_shot_q  = ctl_q.one_shot_select;
  end

  // enable may come with the same write as run
  assign en_after_wr = reg_wdata[ENABLE_BIT] || ctl_q.channel_enable;

  // one-shot end point: max going up, zero going down or up/down
  always_comb begin
    one_shot_end = 1'b0;
    if (ctl_q.one_shot_select) begin
      if (ctl_q.count_direction_select == DIR_UP) begin
        one_shot_end = cnt_event.max_hit;
      end else begin
        one_shot_end = cnt_event.zero_hit;
      end
    end
  end

  // run state; a software write in the same cycle wins over the end point
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_run_q <= 1'b0;
    end else if (wr_ctl) begin
      if (reg_wdata[RUN_BIT]) begin
        count_run_q <= count_run_q || en_after_wr;
      end else begin
        count_run_q <= 1'b0;
      end
    end else if (count_run_q && one_shot_end) begin
      count_run_q <= 1'b0;
    end
  end

  // preset pulses to the counter, only with the channel enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      preset_clear_q    <= 1'b0;
      preset_load_max_q <= 1'b0;
    end else begin
      preset_clear_q    <= wr_ctl && reg_wdata[PRESET_BIT] && en_after_wr
                           && (dir_wr != DIR_DOWN);
      preset_load_max_q <= wr_ctl && reg_wdata[PRESET_BIT] && en_after_wr
                           && (dir_wr == DIR_DOWN);
    end
  end

  // max register: a write starts a load that needs the channel enabled, even in the debug-mode hold
  assign max_busy = (busy_cnt_q != 4'h0);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q   <= 4'h0;
      max_shadow_q <= MAX_VAL_RESET;
    end else if (wr_max && !max_busy) begin
      // a write during busy is dropped, software must poll first
      busy_cnt_q   <= MAX_LOAD_CYCLES;
      max_shadow_q <= reg_wdata;
    end else if (max_busy && ctl_q.channel_enable) begin
      busy_cnt_q <= busy_cnt_q - 4'h1;
    end
  end

  // new maximum reaches the counter in the cycle that busy clears, with a max_load_q pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      max_value_q <= MAX_VAL_RESET;
      max_load_q  <= 1'b0;
    end else begin
      max_load_q <= 1'b0;
      if (busy_cnt_q == 4'h1 && ctl_q.channel_enable) begin
        max_value_q <= max_shadow_q;
        max_load_q  <= 1'b1;
      end
    end
  end

  // per-system set conditions, counter end set conditions
  assign flag_set[ZERO_FLAG_BIT] = cnt_event.zero_hit;
  assign flag_set[MAX_FLAG_BIT]  = cnt_event.max_hit;

  genvar m;
  generate
    for (m = 0; m < NUM_CC; m++) begin : g_cc
      assign flag_set[CC_FLAG_BASE + 2*m] =
        (!cc_capture_mode[m] && cc_match[m])
        || (cc_capture_mode[m] && cc_capture_load[m]);
      assign flag_set[CC_FLAG_BASE + 2*m + 1] =
        cc_capture_mode[m] && cc_capture_load[m]
        && flag_q[CC_FLAG_BASE + 2*m];
    end
  endgenerate

  assign flag_clr = wr_flag ? reg_wdata[FLAG_W-1:0] : '0;

  // sticky flags: write one to clear, a set in the same cycle wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // interrupt enable mask
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_en_q <= '0;
    end else if (wr_en_reg) begin
      int_en_q <= reg_wdata[FLAG_W-1:0];
    end
  end

  // request follows the registered flags, so it lags a set by one cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flag_q & int_en_q);
    end
  end

  // read mux; unused and unmapped bits read zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      CLK_SEL_OFFSET: begin
        rd_mux[DBG_RUN_BIT]   = clk_sel_q.debug_run;
        rd_mux[DIV_LSB +: 4]  = clk_sel_q.clock_divider_select;
        rd_mux[SRC_LSB +: 3]  = clk_sel_q.clock_source_select;
      end
      CNT_CTL_OFFSET: begin
        rd_mux[MAX_BUSY_BIT]  = max_busy;
        rd_mux[DIR_LSB +: 2]  = ctl_q.count_direction_select;
        rd_mux[ONE_SHOT_BIT]  = ctl_q.one_shot_select;
        rd_mux[RUN_BIT]       = count_run_q;
        rd_mux[ENABLE_BIT]    = ctl_q.channel_enable;
      end
      INT_FLAG_OFFSET: rd_mux[FLAG_W-1:0] = flag_q;
      INT_EN_OFFSET:   rd_mux[FLAG_W-1:0] = int_en_q;
      MAX_VAL_OFFSET:  rd_mux = max_value_q;
      default:         rd_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= '0;
    end
  end

endmodule

//--- logic/pwm_ctrl_pkg.sv
// shared constants and types for the pwm timer control block
package pwm_ctrl_pkg;

  // register map, byte addresses
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 16;
  localparam logic [7:0]  CLK_SEL_OFFSET    = 8'h00;
  localparam logic [7:0]  CNT_CTL_OFFSET    = 8'h04;
  localparam logic [7:0]  INT_FLAG_OFFSET   = 8'h08;
  localparam logic [7:0]  INT_EN_OFFSET     = 8'h0c;
  localparam logic [7:0]  MAX_VAL_OFFSET    = 8'h10;

  // clock control field positions
  localparam int unsigned DBG_RUN_BIT       = 8;
  localparam int unsigned DIV_LSB           = 4;
  localparam int unsigned SRC_LSB           = 0;

  // counter control field positions
  localparam int unsigned MAX_BUSY_BIT      = 8;
  localparam int unsigned DIR_LSB           = 4;
  localparam int unsigned ONE_SHOT_BIT      = 3;
  localparam int unsigned RUN_BIT           = 2;
  localparam int unsigned PRESET_BIT        = 1;
  localparam int unsigned ENABLE_BIT        = 0;

  // interrupt flag positions
  localparam int unsigned ZERO_FLAG_BIT     = 0;
  localparam int unsigned MAX_FLAG_BIT      = 1;
  localparam int unsigned CC_FLAG_BASE      = 2;

  // reset values
  localparam logic [3:0]  DIV_RESET         = 4'h0;
  localparam logic [2:0]  SRC_RESET         = 3'h0;
  localparam logic [15:0] MAX_VAL_RESET     = 16'hffff;

  // divider limits per source family
  localparam logic [3:0]  LOW_SPEED_DIV_MAX = 4'h8;
  localparam logic [7:0]  SRC_ALL_SUPPORTED = 8'hff;

  // cycles the max register needs to take a new value
  localparam logic [3:0]  MAX_LOAD_CYCLES   = 4'h3;

  typedef enum logic [2:0] {
    SRC_INT_OSC  = 3'h0,
    SRC_LOW_OSC  = 3'h1,
    SRC_HIGH_OSC = 3'h2,
    SRC_EXT_OSC  = 3'h3,
    SRC_EXT_IN0  = 3'h4,
    SRC_EXT_IN1  = 3'h5,
    SRC_EXT_IN0N = 3'h6,
    SRC_EXT_IN1N = 3'h7
  } clk_src_t;

  typedef enum logic [1:0] {
    DIR_UP      = 2'h0,
    DIR_DOWN    = 2'h1,
    DIR_UP_DOWN = 2'h2,
    DIR_RSVD    = 2'h3
  } count_dir_t;

  typedef struct packed {
    logic       debug_run;
    logic [3:0] clock_divider_select;
    clk_src_t   clock_source_select;
  } clk_sel_t;

  typedef struct packed {
    count_dir_t count_direction_select;
    logic       one_shot_select;
    logic       channel_enable;
  } cnt_ctl_t;

  // counter end events from the counter datapath
  typedef struct packed {
    logic max_hit;
    logic zero_hit;
  } cnt_event_t;

endpackage

//--- logic/clock_prescaler.sv
// counter clock divider: one tick per 2^code source ticks
`timescale 1ns/1ps
module clock_prescaler
  import pwm_ctrl_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       gate_en,
  input  wire logic       src_tick,
  input  wire logic [3:0] div_code,
  output logic            tick_q
);

  logic [14:0] div_cnt_q;
  logic [15:0] div_mask;
  logic        div_hit;

  // low code bits all ones marks the last source tick of a period
  always_comb begin
    div_mask = (16'h0001 << div_code) - 16'h0001;
    div_hit  = (({1'b0, div_cnt_q} & div_mask) == div_mask);
  end

  // count stays at zero while gated so a restart begins a fresh period
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 15'h0000;
    end else if (!gate_en) begin
      div_cnt_q <= 15'h0000;
    end else if (src_tick) begin
      div_cnt_q <= div_cnt_q + 15'h0001;
    end
  end

  // output tick
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= gate_en & src_tick & div_hit;
    end
  end

endmodule

//--- bench/pwm_timer_ctrl_monitor.sv
// assertion checker for the pwm timer control block
`timescale 1ns/1ps
module pwm_timer_ctrl_monitor
  import pwm_ctrl_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire cnt_event_t        cnt_event,
  input wire logic              irq_q,
  input wire logic              count_tick_q,
  input wire logic              count_run_q,
  input wire count_dir_t        count_dir_q,
  input wire logic              one_shot_q,
  input wire logic              preset_clear_q,
  input wire logic              preset_load_max_q,
  input wire logic [15:0]       max_value_q,
  input wire logic              max_load_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // register write decode, shared by the run, mode, preset and irq checks
  wire logic       wr_ctl = reg_wr && (reg_addr == CNT_CTL_OFFSET);
  wire logic [1:0] wdir   = reg_wdata[DIR_LSB+:2];
  wire logic       wr_en0 = reg_wr && (reg_addr == INT_EN_OFFSET);

  a_run_start_en: assert property (
    $rose(count_run_q) |-> $past(wr_ctl && reg_wdata[RUN_BIT]
    && reg_wdata[ENABLE_BIT])) else $error("run began without enable");
  a_run_stop_wr: assert property (
    wr_ctl && !reg_wdata[RUN_BIT] |=> !count_run_q)
    else $error("run kept after stop write");
  a_one_shot_end: assert property (
    one_shot_q && count_run_q && !wr_ctl && ((count_dir_q == DIR_UP)
    ? cnt_event.max_hit : cnt_event.zero_hit) |=> !count_run_q)
    else $error("one-shot end left run set");
  a_mode_take: assert property (
    wr_ctl && wdir != 2'h3 |=> count_dir_q == $past(wdir)
    && one_shot_q == $past(reg_wdata[ONE_SHOT_BIT]))
    else $error("mode write not taken");
  a_dir_rsvd: assert property (
    wr_ctl && wdir == 2'h3 |=> $stable(count_dir_q))
    else $error("reserved direction taken");
  a_preset_cause: assert property (
    preset_clear_q || preset_load_max_q |-> $past(wr_ctl
    && reg_wdata[PRESET_BIT]) && !(preset_clear_q && preset_load_max_q)
    && (preset_load_max_q == $past(wdir == DIR_DOWN)))
    else $error("preset pulse without cause");
  a_irq_masked: assert property (
    wr_en0 && reg_wdata == 16'h0000 |-> ##2 !irq_q)
    else $error("irq with all enables off");
  a_max_update: assert property (
    $changed(max_value_q) |-> max_load_q)
    else $error("max changed without load pulse");
  a_tick_run: assert property (
    count_tick_q |-> count_run_q || $past(count_run_q))
    else $error("tick while idle");

  // main scenarios reached
  c_run: cover property ($rose(count_run_q));
  c_load_max: cover property (preset_load_max_q);
  c_max_load: cover property (max_load_q);
  c_irq: cover property (irq_q);
endmodule

//--- bench/pwm_timer_ctrl_bench.sv
// self-checking bench for the pwm timer control block
`timescale 1ns/1ps
module pwm_timer_ctrl_bench
  import pwm_ctrl_pkg::*;
();
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, debug_mode = 1'b0;
  logic [3:0]  osc_tick = 4'h0;
  logic [1:0]  ext_clk_in = 2'h0, cc_capture_mode = 2'h0;
  logic [1:0]  cc_match = 2'h0, cc_capture_load = 2'h0;
  cnt_event_t  cnt_event = '0;
  logic [15:0] reg_rdata_q, max_value_q, fl, nf, c, v;
  logic        irq_q, chan_clk_en_q, count_tick_q, count_run_q, o;
  logic        one_shot_q, preset_clear_q, preset_load_max_q, max_load_q;
  count_dir_t  count_dir_q;
  logic [1:0]  d, pd, cm, ce, m, l;
  logic [3:0]  dv;
  int          n_mismatch = 0, n_tests = 0, n_ticks = 0, s;

  pwm_timer_ctrl #(.NUM_CC(2)) dut_u (
    .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .debug_mode, .osc_tick, .ext_clk_in, .cnt_event,
    .cc_capture_mode, .cc_match, .cc_capture_load, .irq_q, .chan_clk_en_q,
    .count_tick_q, .count_run_q, .count_dir_q, .one_shot_q, .preset_clear_q,
    .preset_load_max_q, .max_value_q, .max_load_q
  );

  // 25 ns clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // counts divided ticks; outputs are registered so the edge sample is safe
  always @(posedge clk_sys) if (count_tick_q === 1'b1) n_ticks <= n_ticks + 1;

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    cyc(1);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the taking edge
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata_q, exp);
  endtask
  task automatic ev(input logic [1:0] mode, e, mt, ld);
    @(posedge clk_sys);
    cc_capture_mode <= mode;
    cnt_event <= cnt_event_t'(e);
    cc_match <= mt;
    cc_capture_load <= ld;
    @(posedge clk_sys);
    cnt_event <= '0;
    cc_match <= 2'h0;
    cc_capture_load <= 2'h0;
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  // sixteen source ticks, so any divider phase gives an exact count
  task automatic tick_case(input logic [15:0] cs, ctl, input int exp);
    do_reset();
    wr(CLK_SEL_OFFSET, cs);
    wr(CNT_CTL_OFFSET, ctl);
    n_ticks = 0;
    repeat (16) begin
      @(posedge clk_sys);
      if (cs[2] == 1'b0) osc_tick[cs[1:0]] <= 1'b1;
      else ext_clk_in[cs[0]] <= 1'b1;
      @(posedge clk_sys);
      osc_tick <= 4'h0;
      @(posedge clk_sys);
      ext_clk_in <= 2'h0;
      @(posedge clk_sys);
    end
    cyc(4);
    chk("ticks", 16'(n_ticks), 16'(exp));
  endtask
  function automatic int exp_ticks(input int src, input logic [3:0] dvs);
    if (src == 0 || src == 2) return 16 >> dvs;
    if (src == 1 && dvs <= LOW_SPEED_DIV_MAX) return 16 >> dvs;
    return 16;
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hang costs a mismatch and ends the run
  initial begin
    #500us;
    n_mismatch++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hd340b241));
    do_reset();
    for (int i = 0; i < 6; i++) rc(8'(4 * i), (i == 4) ? 16'hffff : 16'h0);
    wr(CLK_SEL_OFFSET, 16'hffff);
    rc(CLK_SEL_OFFSET, 16'h01f7);
    wr(CNT_CTL_OFFSET, 16'hffc4);
    rc(CNT_CTL_OFFSET, 16'h0000);
    wr(CNT_CTL_OFFSET, 16'h0001);
    wr(CNT_CTL_OFFSET, 16'h0005);
    rc(CNT_CTL_OFFSET, 16'h0005);
    chk("clk_en", 16'(chan_clk_en_q), 16'h1);
    wr(CNT_CTL_OFFSET, 16'h0001);
    chk("run", 16'(count_run_q), 16'h0);
    pd = 2'h0;
    o = 1'b0;
    // random modes; a reserved code keeps the one-shot bit so either
    // reading of a refused write gives the same expectation
    repeat (8) begin
      d = 2'($urandom_range(0, 3));
      if (d != 2'h3) o = 1'($urandom_range(0, 1));
      if (d != 2'h3) pd = d;
      wr(CNT_CTL_OFFSET, {10'h0, d, o, 3'b001});
      chk("dir", 16'(count_dir_q), 16'(pd));
      rc(CNT_CTL_OFFSET, {10'h0, pd, o, 3'b001});
    end
    wr(CNT_CTL_OFFSET, 16'h0013);
    chk("preset", {preset_load_max_q, preset_clear_q}, 16'h2);
    wr(CNT_CTL_OFFSET, 16'h0003);
    chk("preset", {preset_load_max_q, preset_clear_q}, 16'h1);
    wr(CNT_CTL_OFFSET, 16'h0000);
    wr(CNT_CTL_OFFSET, 16'h0002);
    chk("preset", {preset_load_max_q, preset_clear_q}, 16'h0);
    wr(CNT_CTL_OFFSET, 16'h000d);
    ev(2'h0, 2'b01, 2'h0, 2'h0);
    cyc(1);
    chk("run", 16'(count_run_q), 16'h1);
    ev(2'h0, 2'b10, 2'h0, 2'h0);
    cyc(1);
    chk("run", 16'(count_run_q), 16'h0);
    wr(CNT_CTL_OFFSET, 16'h001d);
    ev(2'h0, 2'b01, 2'h0, 2'h0);
    cyc(1);
    chk("run", 16'(count_run_q), 16'h0);
    v = 16'($urandom_range(1, 16'hfffe));
    wr(MAX_VAL_OFFSET, v);
    wr(MAX_VAL_OFFSET, ~v);
    cyc(6);
    chk("max", max_value_q, v);
    wr(MAX_VAL_OFFSET, ~v);
    rc(CNT_CTL_OFFSET, 16'h0119);
    cyc(6);
    rc(MAX_VAL_OFFSET, ~v);
    rc(CNT_CTL_OFFSET, 16'h0019);
    $display("registers done");

    // the one-shot cases above left the zero and max flags set
    rc(INT_FLAG_OFFSET, 16'h0003);
    wr(INT_FLAG_OFFSET, 16'h003f);
    fl = 16'h0;
    wr(INT_EN_OFFSET, 16'h003f);
    repeat (3) begin
      repeat (12) begin
        cm = 2'($urandom);
        ce = 2'($urandom);
        m = 2'($urandom);
        l = 2'($urandom);
        ev(cm, ce, m, l);
        nf = fl | {14'h0, ce};
        for (int k = 0; k < 2; k++) begin
          if (cm[k] && l[k] && fl[2 + 2 * k]) nf[3 + 2 * k] = 1'b1;
          if ((cm[k] && l[k]) || (!cm[k] && m[k])) nf[2 + 2 * k] = 1'b1;
        end
        fl = nf;
      end
      rc(INT_FLAG_OFFSET, fl);
      wr(INT_FLAG_OFFSET, 16'h0000);
      rc(INT_FLAG_OFFSET, fl);
      c = 16'($urandom) & 16'h003f;
      wr(INT_FLAG_OFFSET, c);
      fl = fl & ~c;
      rc(INT_FLAG_OFFSET, fl);
      c = 16'($urandom) & 16'h003f;
      wr(INT_EN_OFFSET, c);
      cyc(2);
      chk("irq", 16'(irq_q), 16'(|(fl & c)));
      wr(INT_EN_OFFSET, 16'h0000);
      cyc(2);
      chk("irq", 16'(irq_q), 16'h0);
      wr(INT_EN_OFFSET, 16'h003f);
    end
    $display("flags done");

    for (int i = 0; i < 10; i++) begin
      s = (i < 8) ? i : 2 * i - 15;
      dv = (i < 8) ? 4'($urandom_range(0, 4)) : 4'($urandom_range(9, 15));
      tick_case({8'h00, dv, 1'b0, 3'(s)}, 16'h0005, exp_ticks(s, dv));
    end
    debug_mode <= 1'b1;
    tick_case(16'h0000, 16'h0005, 0);
    tick_case(16'h0100, 16'h0005, 16);
    debug_mode <= 1'b0;
    tick_case(16'h0000, 16'h0004, 0);
    $display("clocks done");
    end_sim();
  end
endmodule

bind pwm_timer_ctrl pwm_timer_ctrl_monitor mon_u (
  .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .cnt_event, .irq_q,
  .count_tick_q, .count_run_q, .count_dir_q, .one_shot_q, .preset_clear_q,
  .preset_load_max_q, .max_value_q, .max_load_q
);
